// ---- hdl/ltx_tx_config.sv ----
// transmit config, frame serializer and receive dma selection behind an axi4-lite slave
`timescale 1ns/1ns
module ltx_tx_config
  import ltx_pkg::*;
#(
  parameter int unsigned BUF_DEPTH = 2048
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ltx_mac_events_s mac_events,
  input wire logic auto_port_choice_aui,
  input wire logic rx_buffer_short,
  input wire logic link_pulse_present,
  output ltx_mac_ctrl_s mac_ctrl,
  output logic [EV_W-1:0] event_request,
  output logic tx_serial_data,
  output logic tx_serial_active
);

  typedef struct packed {
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] line_control;
    logic [15:0] tx_interrupt_config;
    logic [15:0] buffer_interrupt_config;
    logic [15:0] rx_config;
    logic [15:0] test_control;
    logic [15:0] tx_command;
    logic [10:0] tx_length;
    logic bid_valid;
    logic bid_error;
    logic [10:0] wr_count;
    ltx_tx_state_e tx_state;
    logic [10:0] byte_idx;
    logic [2:0] bit_idx;
    logic [4:0] crc_idx;
    logic [3:0] pre_idx;
    logic [7:0] tick;
    logic [31:0] crc;
    logic serial_data;
    logic serial_active;
    logic [2:0] link_sync;
    logic link_ok;
    logic [EV_W-1:0] event_request;
    ltx_mac_ctrl_s ctrl;
  } ltx_state_s;

  ltx_state_s st;
  ltx_state_s next_st;
  logic [7:0] tx_buffer [BUF_DEPTH];
  logic mem_we;
  logic [10:0] mem_addr;
  logic [7:0] mem_wdata;

  // combinational decode helpers
  logic wr_fire;
  logic rd_fire;
  logic [7:0] cur_byte;
  logic cur_bit;
  logic crc_on;
  logic pad_on;
  logic tx_allowed;
  logic [10:0] start_level;
  logic [10:0] min_len;
  logic underrun;
  logic space_freed;
  logic [EV_W-1:0] raw_events;
  logic [EV_W-1:0] enables;

  assign s_axi_awready = !st.aw_held && !st.bvalid;
  assign s_axi_wready = !st.w_held && !st.bvalid;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign mac_ctrl = st.ctrl;
  assign event_request = st.event_request;
  assign tx_serial_data = st.serial_data;
  assign tx_serial_active = st.serial_active;
  assign cur_byte = tx_buffer[st.byte_idx];

  // per-frame options taken from the latched command
  always_comb begin
    crc_on = !st.tx_command[CMD_INHIBIT_CRC];
    pad_on = !st.tx_command[CMD_PAD_DISABLE] && crc_on;
    min_len = pad_on ? FRAME_MIN_NO_CRC : 11'd0;
    // field order is {bit 7, bit 6}: bit 7 alone means 381, bit 6 alone 1021
    case (st.tx_command[CMD_START_HI:CMD_START_LO])
      2'b00: start_level = START_AFTER_5;
      2'b10: start_level = START_AFTER_381;
      2'b01: start_level = START_AFTER_1021;
      default: start_level = st.tx_length;
    endcase
    if (start_level > st.tx_length) begin
      start_level = st.tx_length;
    end
    // port gate: forced attachment port, else auto choice, else twisted pair link test
    tx_allowed = st.line_control[LC_TX_SERIAL_ENABLE] &&
                 (st.ctrl.aui_select || st.link_ok || st.test_control[TST_LINK_TEST_DISABLE]);
  end

  // enable mask applied in the same cycle as each event
  always_comb begin
    enables = '0;
    enables[EV_CARRIER_LOSS] = st.tx_interrupt_config[TC_CARRIER_LOSS] && st.ctrl.aui_select;
    enables[EV_HEARTBEAT_ERROR] = st.tx_interrupt_config[TC_HEARTBEAT_ERROR];
    enables[EV_TX_DONE] = st.tx_interrupt_config[TC_TX_DONE];
    enables[EV_LATE_COLLISION] = st.tx_interrupt_config[TC_LATE_COLLISION];
    enables[EV_JABBER] = st.tx_interrupt_config[TC_JABBER];
    enables[EV_COLLISION] = st.tx_interrupt_config[TC_COLLISION];
    enables[EV_EXCESS_RETRY] = st.tx_interrupt_config[TC_EXCESS_RETRY];
    enables[EV_TX_SPACE] = st.buffer_interrupt_config[BC_TX_SPACE];
    enables[EV_TX_UNDERRUN] = st.buffer_interrupt_config[BC_TX_UNDERRUN];
    enables[EV_COLLISION_COUNT_WRAP] = st.buffer_interrupt_config[BC_COLLISION_COUNT_WRAP];
  end

  // whole next-state logic
  always_comb begin
    next_st = st;
    mem_we = 1'b0;
    mem_addr = st.wr_count;
    mem_wdata = st.wdata[7:0];
    wr_fire = 1'b0;
    rd_fire = s_axi_arvalid && !st.rvalid;
    underrun = 1'b0;
    space_freed = 1'b0;
    cur_bit = 1'b0;

    // write channel capture, either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_held = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_held = 1'b1;
      next_st.wdata = s_axi_wdata;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_held && st.w_held && !st.bvalid) begin
      wr_fire = 1'b1;
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
    end

    // tick of the 10 Mb/s bit clock, runs while a frame or its last bit cell is out
    next_st.tick = ((st.tx_state == TX_IDLE && !st.serial_active) || st.tick == BIT_LAST) ? 8'h00 : st.tick + 8'h01;

    // serializer, one bit per tick wrap
    if (st.tx_state != TX_IDLE && !st.line_control[LC_TX_SERIAL_ENABLE]) begin
      next_st.tx_state = TX_IDLE;
      next_st.serial_active = 1'b0;
      next_st.serial_data = 1'b0;
    end else if (st.tx_state != TX_IDLE && st.tick == BIT_LAST) begin
      next_st.serial_active = 1'b1;
      next_st.bit_idx = st.bit_idx + 3'd1;
      case (st.tx_state)
        TX_PREAMBLE: begin
          cur_bit = (st.pre_idx == PREAMBLE_BYTES) ? SFD_BYTE[st.bit_idx] : PREAMBLE_BYTE[st.bit_idx];
          if (st.bit_idx == 3'd7) begin
            next_st.pre_idx = st.pre_idx + 4'd1;
            if (st.pre_idx == PREAMBLE_BYTES) begin
              next_st.tx_state = TX_DATA;
              next_st.byte_idx = 11'd0;
              underrun = (st.wr_count == 11'd0);
            end
          end
        end
        TX_DATA: begin
          cur_bit = cur_byte[st.bit_idx];
          next_st.crc = {1'b0, st.crc[31:1]} ^ ((st.crc[0] ^ cur_bit) ? CRC_POLY : 32'h00000000);
          if (st.bit_idx == 3'd7) begin
            next_st.byte_idx = st.byte_idx + 11'd1;
            if (st.byte_idx + 11'd1 == st.tx_length) begin
              if (st.tx_length < min_len) begin
                next_st.tx_state = TX_PAD;
              end else if (crc_on) begin
                next_st.tx_state = TX_CRC;
              end else begin
                next_st.tx_state = TX_IDLE;
              end
            end else if (st.byte_idx + 11'd1 >= st.wr_count) begin
              underrun = 1'b1;
            end
          end
        end
        TX_PAD: begin
          cur_bit = 1'b0;
          next_st.crc = {1'b0, st.crc[31:1]} ^ (st.crc[0] ? CRC_POLY : 32'h00000000);
          if (st.bit_idx == 3'd7) begin
            next_st.byte_idx = st.byte_idx + 11'd1;
            if (st.byte_idx + 11'd1 == min_len) begin
              next_st.tx_state = TX_CRC;
            end
          end
        end
        TX_CRC: begin
          cur_bit = ~st.crc[st.crc_idx];
          next_st.crc_idx = st.crc_idx + 5'd1;
          if (st.crc_idx == 5'd31) begin
            next_st.tx_state = TX_IDLE;
          end
        end
        default: begin
          next_st.tx_state = TX_IDLE;
        end
      endcase
      next_st.serial_data = cur_bit;
      if (underrun) begin
        next_st.tx_state = TX_IDLE;
      end
    end else if (st.tx_state == TX_IDLE && (!st.serial_active || st.tick == BIT_LAST)) begin
      // last bit keeps its full cell before the line goes quiet
      next_st.serial_active = 1'b0;
      next_st.serial_data = 1'b0;
    end

    // frame finished or dropped: buffer free for the next bid
    if (st.tx_state != TX_IDLE && next_st.tx_state == TX_IDLE) begin
      next_st.bid_valid = 1'b0;
      next_st.wr_count = 11'd0;
      space_freed = 1'b1;
    end

    // start once the programmed amount is buffered
    if (st.tx_state == TX_IDLE && !st.serial_active && st.bid_valid && tx_allowed && st.wr_count >= start_level) begin
      next_st.tx_state = TX_PREAMBLE;
      next_st.pre_idx = 4'd0;
      next_st.bit_idx = 3'd0;
      next_st.crc_idx = 5'd0;
      next_st.crc = CRC_INIT;
    end

    // register writes
    if (wr_fire) begin
      case (st.awaddr)
        OFS_LINE_CONTROL: next_st.line_control = st.wdata[15:0];
        OFS_TX_INTERRUPT_CONFIG: next_st.tx_interrupt_config = st.wdata[15:0];
        OFS_BUFFER_INTERRUPT_CONFIG: next_st.buffer_interrupt_config = st.wdata[15:0];
        OFS_RX_CONFIG: next_st.rx_config = st.wdata[15:0];
        OFS_TEST_CONTROL: next_st.test_control = st.wdata[15:0];
        OFS_TX_COMMAND: begin
          next_st.tx_command = st.wdata[15:0];
          next_st.bid_valid = 1'b0;
          next_st.bid_error = 1'b0;
          if (st.wdata[CMD_FORCE]) begin
            next_st.tx_state = TX_IDLE;
            next_st.wr_count = 11'd0;
          end
        end
        OFS_TX_LENGTH: begin
          if (st.wdata[15:0] < 16'(TX_LEN_MIN) || st.wdata[15:0] > 16'(TX_LEN_MAX)) begin
            next_st.bid_error = 1'b1;
          end else if (st.tx_state == TX_IDLE) begin
            next_st.tx_length = st.wdata[10:0];
            next_st.bid_valid = 1'b1;
            next_st.wr_count = 11'd0;
            space_freed = 1'b1;
          end
        end
        OFS_TX_DATA: begin
          if (st.bid_valid && st.wr_count < st.tx_length) begin
            mem_we = 1'b1;
            next_st.wr_count = st.wr_count + 11'd1;
          end
        end
        OFS_STATUS: begin
        end
        default: next_st.bresp = RESP_SLVERR;
      endcase
    end

    // read channel, one cycle answer
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (rd_fire) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      next_st.rdata = 32'h00000000;
      case (s_axi_araddr)
        OFS_LINE_CONTROL: next_st.rdata[15:0] = st.line_control;
        OFS_TX_INTERRUPT_CONFIG: next_st.rdata[15:0] = st.tx_interrupt_config;
        OFS_BUFFER_INTERRUPT_CONFIG: next_st.rdata[15:0] = st.buffer_interrupt_config;
        OFS_RX_CONFIG: next_st.rdata[15:0] = st.rx_config;
        OFS_TEST_CONTROL: next_st.rdata[15:0] = st.test_control;
        OFS_TX_COMMAND: next_st.rdata[15:0] = st.tx_command;
        OFS_TX_LENGTH: next_st.rdata[10:0] = st.tx_length;
        OFS_TX_DATA: next_st.rdata = 32'h00000000;
        OFS_STATUS: begin
          next_st.rdata[0] = st.bid_valid && st.tx_state == TX_IDLE;
          next_st.rdata[1] = st.bid_error;
          next_st.rdata[2] = st.tx_state != TX_IDLE;
          next_st.rdata[3] = st.link_ok;
          next_st.rdata[4] = st.ctrl.aui_select;
          next_st.rdata[5] = st.ctrl.rx_use_dma;
          next_st.rdata[26:16] = st.wr_count;
        end
        default: next_st.rresp = RESP_SLVERR;
      endcase
    end

    // link pulse pin: three stages, accept when last two agree
    next_st.link_sync = {st.link_sync[1:0], link_pulse_present};
    if (st.link_sync[2] == st.link_sync[1]) begin
      next_st.link_ok = st.link_sync[2];
    end

    // port and backoff settings to the mac engine
    if (st.line_control[LC_ATTACHMENT_PORT_FORCE]) begin
      next_st.ctrl.aui_select = 1'b1;
    end else if (st.line_control[LC_AUTO_PORT_SELECT]) begin
      next_st.ctrl.aui_select = auto_port_choice_aui;
    end else begin
      next_st.ctrl.aui_select = 1'b0;
    end
    next_st.ctrl.modified_backoff_enable = st.line_control[LC_MODIFIED_BACKOFF_ENABLE];
    next_st.ctrl.two_part_deferral_disable = st.line_control[LC_TWO_PART_DEFERRAL_DISABLE];

    // receive dma mode selection
    if (st.rx_config[RC_RX_DMA_ALWAYS]) begin
      next_st.ctrl.rx_use_dma = 1'b1;
      next_st.ctrl.rx_buffer_irq_allowed = st.buffer_interrupt_config[BC_RX_DMA_FRAME];
      next_st.ctrl.rx_event_irq_allowed = 1'b0;
    end else if (st.rx_config[RC_RX_DMA_AUTO_SWITCH]) begin
      next_st.ctrl.rx_use_dma = rx_buffer_short;
      next_st.ctrl.rx_buffer_irq_allowed = st.buffer_interrupt_config[BC_RX_DMA_FRAME];
      next_st.ctrl.rx_event_irq_allowed = st.rx_config[RC_RX_GOOD];
    end else begin
      next_st.ctrl.rx_use_dma = 1'b0;
      next_st.ctrl.rx_buffer_irq_allowed = 1'b0;
      next_st.ctrl.rx_event_irq_allowed = st.rx_config[RC_RX_GOOD];
    end

    // events gated by the enables of this very cycle
    raw_events = '0;
    raw_events[EV_CARRIER_LOSS] = mac_events.carrier_loss;
    raw_events[EV_HEARTBEAT_ERROR] = mac_events.heartbeat_error;
    raw_events[EV_TX_DONE] = mac_events.tx_done;
    raw_events[EV_LATE_COLLISION] = mac_events.late_collision;
    raw_events[EV_JABBER] = mac_events.jabber;
    raw_events[EV_COLLISION] = mac_events.collision;
    raw_events[EV_EXCESS_RETRY] = mac_events.excess_retry;
    raw_events[EV_TX_SPACE] = space_freed;
    raw_events[EV_TX_UNDERRUN] = underrun;
    raw_events[EV_COLLISION_COUNT_WRAP] = mac_events.collision_count_wrap;
    next_st.event_request = raw_events & enables;
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.tx_state <= TX_IDLE;
      st.line_control <= RST_REG;
      st.tx_interrupt_config <= RST_REG;
      st.buffer_interrupt_config <= RST_REG;
      st.rx_config <= RST_REG;
      st.test_control <= RST_REG;
      st.tx_command <= RST_REG;
    end else begin
      st <= next_st;
    end
  end

  // transmit buffer storage
  always_ff @(posedge aclk) begin
    if (mem_we) begin
      tx_buffer[mem_addr] <= mem_wdata;
    end
  end

endmodule

// ---- hdl/ltx_pkg.sv ----
// package: register map, field positions, timing and carrier types of the transmit config block
package ltx_pkg;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned BIT_TIME_NS = 100;
  localparam int unsigned BIT_CYCLES = (BIT_TIME_NS / CLK_PERIOD_NS > 0) ? BIT_TIME_NS / CLK_PERIOD_NS : 1;
  localparam logic [7:0] BIT_LAST = 8'(BIT_CYCLES - 1);
  // register byte addresses
  localparam logic [7:0] OFS_LINE_CONTROL = 8'h00;
  localparam logic [7:0] OFS_TX_INTERRUPT_CONFIG = 8'h04;
  localparam logic [7:0] OFS_BUFFER_INTERRUPT_CONFIG = 8'h08;
  localparam logic [7:0] OFS_RX_CONFIG = 8'h0C;
  localparam logic [7:0] OFS_TEST_CONTROL = 8'h10;
  localparam logic [7:0] OFS_TX_COMMAND = 8'h14;
  localparam logic [7:0] OFS_TX_LENGTH = 8'h18;
  localparam logic [7:0] OFS_TX_DATA = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  // line_control fields
  localparam int unsigned LC_TX_SERIAL_ENABLE = 7;
  localparam int unsigned LC_ATTACHMENT_PORT_FORCE = 8;
  localparam int unsigned LC_AUTO_PORT_SELECT = 9;
  localparam int unsigned LC_MODIFIED_BACKOFF_ENABLE = 11;
  localparam int unsigned LC_TWO_PART_DEFERRAL_DISABLE = 13;
  // tx_interrupt_config fields
  localparam int unsigned TC_CARRIER_LOSS = 6;
  localparam int unsigned TC_HEARTBEAT_ERROR = 7;
  localparam int unsigned TC_TX_DONE = 8;
  localparam int unsigned TC_LATE_COLLISION = 9;
  localparam int unsigned TC_JABBER = 10;
  localparam int unsigned TC_COLLISION = 11;
  localparam int unsigned TC_EXCESS_RETRY = 15;
  // buffer_interrupt_config fields
  localparam int unsigned BC_RX_DMA_FRAME = 7;
  localparam int unsigned BC_TX_SPACE = 8;
  localparam int unsigned BC_TX_UNDERRUN = 9;
  localparam int unsigned BC_COLLISION_COUNT_WRAP = 12;
  // rx_config fields
  localparam int unsigned RC_RX_GOOD = 8;
  localparam int unsigned RC_RX_DMA_ALWAYS = 9;
  localparam int unsigned RC_RX_DMA_AUTO_SWITCH = 10;
  // test_control field
  localparam int unsigned TST_LINK_TEST_DISABLE = 7;
  // tx_command fields
  localparam int unsigned CMD_START_LO = 6;
  localparam int unsigned CMD_START_HI = 7;
  localparam int unsigned CMD_FORCE = 8;
  localparam int unsigned CMD_INHIBIT_CRC = 12;
  localparam int unsigned CMD_PAD_DISABLE = 13;
  // reset values of the configuration registers
  localparam logic [15:0] RST_REG = 16'h0000;
  // frame figures
  localparam logic [10:0] START_AFTER_5 = 11'd5;
  localparam logic [10:0] START_AFTER_381 = 11'd381;
  localparam logic [10:0] START_AFTER_1021 = 11'd1021;
  localparam logic [10:0] FRAME_MIN_NO_CRC = 11'd60;
  localparam logic [10:0] TX_LEN_MIN = 11'd3;
  localparam logic [10:0] TX_LEN_MAX = 11'd1514;
  localparam logic [3:0] PREAMBLE_BYTES = 4'd7;
  localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
  localparam logic [7:0] SFD_BYTE = 8'hD5;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // event request positions
  localparam int unsigned EV_W = 10;
  localparam int unsigned EV_CARRIER_LOSS = 0;
  localparam int unsigned EV_HEARTBEAT_ERROR = 1;
  localparam int unsigned EV_TX_DONE = 2;
  localparam int unsigned EV_LATE_COLLISION = 3;
  localparam int unsigned EV_JABBER = 4;
  localparam int unsigned EV_COLLISION = 5;
  localparam int unsigned EV_EXCESS_RETRY = 6;
  localparam int unsigned EV_TX_SPACE = 7;
  localparam int unsigned EV_TX_UNDERRUN = 8;
  localparam int unsigned EV_COLLISION_COUNT_WRAP = 9;

  typedef enum logic [2:0] {TX_IDLE, TX_PREAMBLE, TX_DATA, TX_PAD, TX_CRC} ltx_tx_state_e;

  // events reported by the mac engine, one-cycle pulses
  typedef struct packed {
    logic carrier_loss;
    logic heartbeat_error;
    logic tx_done;
    logic late_collision;
    logic jabber;
    logic collision;
    logic excess_retry;
    logic collision_count_wrap;
  } ltx_mac_events_s;

  // settings handed to the mac engine and the receive path
  typedef struct packed {
    logic aui_select;
    logic modified_backoff_enable;
    logic two_part_deferral_disable;
    logic rx_use_dma;
    logic rx_buffer_irq_allowed;
    logic rx_event_irq_allowed;
  } ltx_mac_ctrl_s;
endpackage

// ---- verif/ltx_tx_config_chk.sv ----
// port assertions of the transmit config block
`timescale 1ns/1ns
module ltx_tx_config_chk
  import ltx_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire ltx_mac_events_s mac_events,
  input wire ltx_mac_ctrl_s mac_ctrl,
  input wire logic [EV_W-1:0] event_request,
  input wire logic tx_serial_data,
  input wire logic tx_serial_active
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // bus steps
  sequence s_aw_bad;
    s_axi_awvalid && s_axi_awready && s_axi_awaddr > OFS_STATUS;
  endsequence
  sequence s_ar_bad;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > OFS_STATUS;
  endsequence
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready during response");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_write_unmapped: assert property (s_aw_bad |-> ##[1:4] s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  a_read_unmapped: assert property (s_ar_bad |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_done_cause: assert property (event_request[EV_TX_DONE] |-> $past(mac_events.tx_done))
    else $error("tx done request without event");
  a_loss_aui: assert property (event_request[EV_CARRIER_LOSS] |-> $past(mac_events.carrier_loss) && $past(mac_ctrl.aui_select))
    else $error("carrier loss request off attachment port");
  a_jabber_cause: assert property (event_request[EV_JABBER] |-> $past(mac_events.jabber))
    else $error("jabber request without event");
  a_wrap_cause: assert property (event_request[EV_COLLISION_COUNT_WRAP] |-> $past(mac_events.collision_count_wrap))
    else $error("wrap request without event");
  a_bit_hold: assert property ($changed(tx_serial_data) && tx_serial_active |=> (!tx_serial_active || $stable(tx_serial_data))[*8])
    else $error("serial bit shorter than a cell");
endmodule

// ---- verif/ltx_mac_model.sv ----
// far side model: event source, link pulses, serial bit capture
`timescale 1ns/1ns
module ltx_mac_model
  import ltx_pkg::*;
(
  input wire logic aclk,
  input wire logic [7:0] ev_cmd,
  input wire logic link_on,
  input wire logic tx_serial_data,
  input wire logic tx_serial_active,
  output ltx_mac_events_s mac_events,
  output logic link_pulse_present,
  output logic [1023:0] bits,
  output int nbits
);
  logic [7:0] phase = 8'h00;
  initial nbits = 0;
  // event pulses and link level
  always @(posedge aclk) begin
    mac_events <= ev_cmd;
    link_pulse_present <= link_on;
  end
  // mid-cell sampling, first bit first
  always @(posedge aclk) begin
    if (!tx_serial_active) begin
      phase <= 8'h00;
    end else begin
      phase <= (phase == BIT_LAST) ? 8'h00 : phase + 8'h01;
      if (phase == 8'h06) begin
        bits[nbits] <= tx_serial_data;
        nbits <= nbits + 1;
      end
    end
  end
endmodule

// ---- verif/tb.sv ----
// testbench of the transmit config block
`timescale 1ns/1ns
module tb;
  import ltx_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ev_cmd = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, crc;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic auto_port_choice_aui = 0, rx_buffer_short = 0, link_on = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic link_pulse_present, tx_serial_data, tx_serial_active;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [EV_W-1:0] event_request;
  logic [1023:0] bits;
  logic [7:0] eb [0:71];
  ltx_mac_events_s mac_events;
  ltx_mac_ctrl_s mac_ctrl;
  int nbits, cyc = 0, err_count = 0, cmp_count = 0;
  localparam logic [19:0] PT [0:6] = '{20'h01004, 20'h03004, 20'h0200C, 20'h02000, 20'h00008, 20'h08002, 20'h20001};
  localparam logic [11:0] RT [0:5] = '{12'h204, 12'h286, 12'h444, 12'h583, 12'h040, 12'h5C7};
  localparam logic [7:0] D [0:2] = '{8'hA1, 8'h5B, 8'hC3};
  ltx_tx_config ltx_tx_config_i (.*);
  ltx_mac_model ltx_mac_model_i (.*);
  always #4 aclk = ~aclk;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw = 1;
    logic w = 1;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
    while (aw || w) begin
      @(negedge aclk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      @(posedge aclk);
      if (!aw) s_axi_awvalid <= 0;
      if (!w) s_axi_wvalid <= 0;
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 0;
    do @(negedge aclk); while (!s_axi_rvalid);
    {rd, rs} = {s_axi_rdata, s_axi_rresp};
    @(posedge aclk);
    s_axi_rready <= 0;
  endtask
  // hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc > 40000) begin
      err_count++;
      conclude();
    end
  end
  // main sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 3; i++) begin
      rdr(8'(4 * i));
      chk("config reset", 32'h0, rd);
      wr(8'(4 * i), 32'h1234ABCD);
      rdr(8'(4 * i));
      chk("config readback", 32'h0000ABCD, rd);
    end
    wr(8'h40, 32'h1);
    chk("unmapped write", 32'(RESP_SLVERR), 32'(rs));
    rdr(8'h40);
    chk("unmapped read", 32'(RESP_SLVERR), 32'(rs));
    for (int i = 0; i < 7; i++) begin
      auto_port_choice_aui <= PT[i][3];
      wr(OFS_LINE_CONTROL, {16'h0, PT[i][19:4]});
      repeat (3) @(negedge aclk);
      chk("port and backoff", 32'(PT[i][2:0]), 32'(mac_ctrl[5:3]));
    end
    for (int i = 0; i < 6; i++) begin
      rx_buffer_short <= RT[i][6];
      wr(OFS_RX_CONFIG, {20'h0, RT[i][11:8], 8'h00});
      wr(OFS_BUFFER_INTERRUPT_CONFIG, {24'h0, RT[i][7], 7'h0});
      repeat (3) @(negedge aclk);
      chk("rx dma mode", 32'(RT[i][2:0]), 32'(mac_ctrl[2:0]));
    end
    wr(OFS_LINE_CONTROL, 32'h0100);
    wr(OFS_TX_INTERRUPT_CONFIG, 32'h8FC0);
    wr(OFS_BUFFER_INTERRUPT_CONFIG, 32'h1300);
    for (int e = 0; e < 2; e++) begin
      for (int i = 0; i < 8; i++) begin
        @(posedge aclk);
        ev_cmd <= 8'h80 >> i;
        @(posedge aclk);
        ev_cmd <= 8'h00;
        @(posedge aclk);
        @(negedge aclk);
        chk("event request", e ? 32'h0 : (i == 7 ? 32'h200 : 32'h1 << i), 32'(event_request));
      end
      wr(OFS_TX_INTERRUPT_CONFIG, 32'h0);
      wr(OFS_BUFFER_INTERRUPT_CONFIG, 32'h0);
    end
    wr(OFS_LINE_CONTROL, 32'h0080);
    wr(OFS_TX_COMMAND, 32'h0);
    wr(OFS_TX_LENGTH, 32'd3);
    rdr(OFS_STATUS);
    chk("ready for data", 32'h1, rd & 32'h1);
    for (int i = 0; i < 3; i++) wr(OFS_TX_DATA, {24'h0, D[i]});
    repeat (200) @(negedge aclk);
    chk("send without link", 32'h0, 32'(nbits));
    wr(OFS_TEST_CONTROL, 32'h80);
    wait (tx_serial_active);
    wait (!tx_serial_active);
    crc = CRC_INIT;
    for (int k = 0; k < 68; k++) begin
      eb[k] = k < 7 ? PREAMBLE_BYTE : k == 7 ? SFD_BYTE : k < 11 ? D[k - 8] : 8'h00;
      if (k > 7) crc = crc ^ {24'h0, eb[k]};
      for (int j = 0; j < 8 && k > 7; j++) crc = crc[0] ? (crc >> 1) ^ CRC_POLY : crc >> 1;
    end
    for (int k = 0; k < 4; k++) eb[68 + k] = ~crc[8 * k +: 8];
    chk("frame bits", 32'd576, 32'(nbits));
    for (int k = 0; k < 72; k++) chk("frame byte", 32'(eb[k]), 32'(bits[8 * k +: 8]));
    // runt frame: no crc, start only once the whole frame is buffered
    wr(OFS_TX_COMMAND, 32'h10C0);
    wr(OFS_TX_LENGTH, 32'd3);
    for (int i = 0; i < 2; i++) wr(OFS_TX_DATA, {24'h0, D[i]});
    repeat (30) @(negedge aclk);
    chk("start before whole frame", 32'h0, 32'(tx_serial_active));
    wr(OFS_TX_DATA, {24'h0, D[2]});
    wait (tx_serial_active);
    wait (!tx_serial_active);
    chk("runt bits", 32'd664, 32'(nbits));
    for (int k = 0; k < 11; k++) chk("runt byte", 32'(eb[k]), 32'(bits[576 + 8 * k +: 8]));
    // 381-byte threshold, then abort by clearing the transmit enable
    wr(OFS_TX_COMMAND, 32'h0080);
    wr(OFS_TX_LENGTH, 32'd400);
    for (int i = 0; i < 380; i++) wr(OFS_TX_DATA, 32'h0);
    repeat (20) @(negedge aclk);
    chk("start at 381", 32'h0, 32'(tx_serial_active));
    wr(OFS_TX_DATA, 32'h0);
    repeat (20) @(negedge aclk);
    chk("start at 381", 32'h1, 32'(tx_serial_active));
    wr(OFS_LINE_CONTROL, 32'h0);
    repeat (2) @(negedge aclk);
    chk("abort on disable", 32'h0, 32'(tx_serial_active));
    conclude();
  end
endmodule
bind ltx_tx_config ltx_tx_config_chk chk_i (.*);
